// File: nrc_pkg.sv
// Package: constants of the navigation receiver command decoder.
// Assumes one core clock; imported by the deframer and the decoder.
package nrc_pkg;
  // Framing bytes
  localparam logic [7:0]  BYTE_DLE        = 8'h10;
  localparam logic [7:0]  BYTE_ETX        = 8'h03;
  // Command identifiers
  localparam logic [7:0]  CMD_ALT_2D      = 8'h2A;
  localparam logic [7:0]  CMD_POS_GEO     = 8'h2B;
  localparam logic [7:0]  CMD_OSC_REQ     = 8'h2D;
  localparam logic [7:0]  CMD_TIME        = 8'h2E;
  localparam logic [7:0]  CMD_LEAP_REQ    = 8'h2F;
  localparam logic [7:0]  CMD_ACC_CART    = 8'h31;
  localparam logic [7:0]  CMD_ACC_GEO     = 8'h32;
  localparam logic [7:0]  CMD_SAT_SEL     = 8'h34;
  localparam logic [7:0]  CMD_OPTIONS     = 8'h35;
  // Report identifiers
  localparam logic [7:0]  RPT_POS_GEO     = 8'h4A;
  localparam logic [7:0]  RPT_POS_INIT    = 8'h4C;
  localparam logic [7:0]  RPT_OSC         = 8'h4D;
  localparam logic [7:0]  RPT_TIME_ACK    = 8'h4E;
  localparam logic [7:0]  RPT_LEAP        = 8'h4F;
  localparam logic [7:0]  RPT_OPTIONS     = 8'h55;
  localparam logic [7:0]  RPT_ACC_POS     = 8'hAC;
  // Payload lengths
  localparam logic [3:0]  LEN_NONE        = 4'h0;
  localparam logic [3:0]  LEN_ONE         = 4'h1;
  localparam logic [3:0]  LEN_SINGLE      = 4'h4;
  localparam logic [3:0]  LEN_TIME        = 4'h6;
  localparam logic [3:0]  LEN_POS         = 4'hC;
  localparam int          PAYLOAD_MAX     = 12;
  // Special values
  localparam logic [7:0]  ALT_CANCEL      = 8'hFF;
  localparam logic [7:0]  SAT_MAX         = 8'h20;
  localparam logic [31:0] ALT_LIMIT_F32   = 32'h468CA000;
  localparam logic [6:0]  SURVEY_FULL     = 7'h64;
  // Option reset values
  localparam logic [31:0] OPT_RESET       = 32'h12020102;
  localparam int          OPT_ALT_IN_BIT  = 27;
  // Register byte offsets
  localparam logic [3:0]  REG_STATUS      = 4'h0;
  localparam logic [3:0]  REG_OPTIONS     = 4'h4;
  localparam logic [3:0]  REG_CTRL        = 4'h8;
  localparam logic [3:0]  REG_REF_ALT     = 4'hC;
  // Control bits
  localparam int          CTRL_SAVE_BIT   = 0;
  // Deframer states
  typedef enum logic [1:0] {
    DF_HUNT,
    DF_ID,
    DF_BODY,
    DF_ESC
  } nrc_df_e;
endpackage

// File: nrc_rx_if.sv
// Interface: deframed packet stream from deframer to decoder.
// Assumes both ends on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface nrc_rx_if;
  logic       start;
  logic [7:0] id;
  logic       data;
  logic [7:0] byte_v;
  logic       done;
  logic       err;
  modport src (output start, output id, output data, output byte_v, output done, output err);
  modport dst (input start, input id, input data, input byte_v, input done, input err);
endinterface
`default_nettype wire

// File: nrc_deframer.sv
// Deframer: strips link escapes and marks packet start, data and end.
// Assumes received bytes arrive as same-clock one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module nrc_deframer
  import nrc_pkg::*;
(
  // Clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_nrst,
  // Received bytes
  input  wire logic  i_rx_valid,
  input  wire logic [7:0] i_rx_byte,
  // Packet stream
  nrc_rx_if.src      rx
);
  nrc_df_e    state_q;
  nrc_df_e    state_d;
  logic [7:0] id_q;
  logic [7:0] byte_q;
  logic       start_q;
  logic       data_q;
  logic       done_q;
  logic       err_q;

  wire is_dle = i_rx_byte == BYTE_DLE;
  wire is_etx = i_rx_byte == BYTE_ETX;

  // Even escape run gives data, odd run before end byte closes packet
  always_comb begin
    state_d = state_q;
    case (state_q)
      DF_HUNT: if (i_rx_valid && is_dle) state_d = DF_ID;
      DF_ID:   if (i_rx_valid) state_d = (is_dle || is_etx) ? DF_HUNT : DF_BODY;
      DF_BODY: if (i_rx_valid && is_dle) state_d = DF_ESC;
      DF_ESC:  if (i_rx_valid) state_d = is_dle ? DF_BODY : DF_HUNT;
      default: state_d = DF_HUNT;
    endcase
  end

  wire take_id   = i_rx_valid && state_q == DF_ID && !is_dle && !is_etx;
  wire take_data = i_rx_valid && ((state_q == DF_BODY && !is_dle) ||
                                  (state_q == DF_ESC && is_dle));
  wire take_end  = i_rx_valid && state_q == DF_ESC && is_etx;
  wire take_err  = i_rx_valid && state_q == DF_ESC && !is_dle && !is_etx;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= DF_HUNT;
      id_q    <= 8'h00;
      byte_q  <= 8'h00;
      start_q <= 1'b0;
      data_q  <= 1'b0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= take_id;
      data_q  <= take_data;
      done_q  <= take_end;
      err_q   <= take_err;
      if (take_id) id_q <= i_rx_byte;
      if (take_data) byte_q <= i_rx_byte;
    end
  end

  assign rx.start  = start_q;
  assign rx.id     = id_q;
  assign rx.data   = data_q;
  assign rx.byte_v = byte_q;
  assign rx.done   = done_q;
  assign rx.err    = err_q;

  a_end_after_esc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_rx_valid && is_etx && state_q == DF_ESC) |=> done_q)
    else $error("end byte after odd escape run did not close packet");
  a_even_esc_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_rx_valid && is_dle && state_q == DF_ESC) |=> (data_q && byte_q == BYTE_DLE))
    else $error("doubled escape not passed as data");
endmodule
`default_nettype wire

// File: nrc_decoder.sv
// Decoder: checks and applies host command packets; answers each accepted one but satellite select.
// Assumes same-clock byte strobes, navigation status levels and report sink.
`timescale 1ns/1ns
`default_nettype none
module nrc_decoder
  import nrc_pkg::*;
#(
  parameter int PAYLOAD_DEPTH = nrc_pkg::PAYLOAD_MAX
)(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // Received link bytes
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  // Navigation status
  input  wire logic        i_navigating,
  input  wire logic        i_time_from_sat,
  input  wire logic        i_sat_acquired,
  input  wire logic [31:0] i_fix3d_alt,
  // Reports
  output logic             o_rpt_valid,
  output logic [7:0]       o_rpt_id,
  input  wire logic        i_rpt_ready,
  // Settings out
  output logic [31:0]      o_alt_used,
  output logic             o_alt_set,
  output logic             o_alt_is_sea_level,
  output logic             o_force_reset,
  output logic [95:0]      o_init_pos,
  output logic             o_init_pos_load,
  output logic             o_pos_accurate,
  output logic [6:0]       o_survey_pct,
  output logic [31:0]      o_tow,
  output logic [15:0]      o_week,
  output logic             o_time_load,
  output logic [7:0]       o_sat_sel,
  output logic [31:0]      o_options,
  output logic             o_nv_store,
  output logic             o_nv_store_pos,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  import nrc_pkg::*;

  nrc_rx_if rx ();

  nrc_deframer u_deframer (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_rx_valid (i_rx_valid),
    .i_rx_byte  (i_rx_byte),
    .rx         (rx.src)
  );

  // Payload capture
  logic [7:0] buf_q [PAYLOAD_DEPTH];
  logic [3:0] len_q;
  logic       long_q;
  logic [7:0] cmd_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      len_q  <= 4'h0;
      long_q <= 1'b0;
      cmd_q  <= 8'h00;
    end else if (rx.start) begin
      len_q  <= 4'h0;
      long_q <= 1'b0;
      cmd_q  <= rx.id;
    end else if (rx.data) begin
      if (len_q == 4'(PAYLOAD_DEPTH)) long_q <= 1'b1;
      else len_q <= len_q + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rx.data && len_q < 4'(PAYLOAD_DEPTH)) buf_q[len_q] <= rx.byte_v;
  end

  // Big-endian word assembly
  function automatic logic [31:0] be_word(input logic [7:0] b0, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic [7:0] b3);
    be_word = {b0, b1, b2, b3};
  endfunction

  // Positive single above limit, compared as magnitude bits
  function automatic logic alt_over(input logic [31:0] f);
    alt_over = !f[31] && (f[30:0] > ALT_LIMIT_F32[30:0]);
  endfunction

  wire [31:0] word0 = be_word(buf_q[0], buf_q[1], buf_q[2], buf_q[3]);
  wire [31:0] word1 = be_word(buf_q[4], buf_q[5], buf_q[6], buf_q[7]);
  wire [31:0] word2 = be_word(buf_q[8], buf_q[9], buf_q[10], buf_q[11]);
  wire [15:0] half2 = {buf_q[4], buf_q[5]};

  // Command decode at packet end
  wire pkt_end    = rx.done && !long_q;
  wire len_none   = len_q == LEN_NONE;
  wire len_one    = len_q == LEN_ONE;
  wire len_single = len_q == LEN_SINGLE;
  wire len_time   = len_q == LEN_TIME;
  wire len_pos    = len_q == LEN_POS;

  wire is_alt  = pkt_end && cmd_q == CMD_ALT_2D;
  wire is_geo  = pkt_end && cmd_q == CMD_POS_GEO;
  wire is_osc  = pkt_end && cmd_q == CMD_OSC_REQ;
  wire is_time = pkt_end && cmd_q == CMD_TIME;
  wire is_leap = pkt_end && cmd_q == CMD_LEAP_REQ;
  wire is_acc  = pkt_end && (cmd_q == CMD_ACC_CART || cmd_q == CMD_ACC_GEO);
  wire is_sat  = pkt_end && cmd_q == CMD_SAT_SEL;
  wire is_opt  = pkt_end && cmd_q == CMD_OPTIONS;

  // Accepted commands, length checked
  wire alt_load   = is_alt && len_single;
  wire alt_cancel = is_alt && len_one && buf_q[0] == ALT_CANCEL;
  wire geo_ok     = is_geo && len_pos;
  wire geo_load   = geo_ok && !i_navigating;
  wire osc_ok     = is_osc && len_none;
  wire time_ok    = is_time && len_time;
  wire time_apply = time_ok && !i_time_from_sat;
  wire leap_ok    = is_leap && len_none;
  wire acc_ok     = is_acc && len_pos;
  wire sat_ok     = is_sat && len_one && buf_q[0] <= SAT_MAX;
  wire opt_query  = is_opt && len_none;
  wire opt_load   = is_opt && len_single;

  wire       any_ok = alt_load || alt_cancel || geo_ok || osc_ok || time_ok || leap_ok ||
                      acc_ok || sat_ok || opt_query || opt_load;
  wire [7:0] rpt_sel = (alt_load || alt_cancel) ? RPT_POS_GEO :
                       geo_ok                   ? RPT_POS_INIT :
                       osc_ok                   ? RPT_OSC :
                       time_ok                  ? RPT_TIME_ACK :
                       leap_ok                  ? RPT_LEAP :
                       acc_ok                   ? RPT_ACC_POS :
                       (opt_query || opt_load)  ? RPT_OPTIONS : 8'h00;
  wire       rpt_want = any_ok && !sat_ok;

  // Retained settings
  logic [31:0] ref_alt_q;
  logic        alt_set_q;
  logic [95:0] pos_q;
  logic        pos_load_q;
  logic        pos_acc_q;
  logic [6:0]  survey_q;
  logic [31:0] tow_q;
  logic [15:0] week_q;
  logic        time_load_q;
  logic [7:0]  sat_q;
  logic [31:0] opt_q;
  logic        nv_q;
  logic        nv_pos_q;
  logic        force_q;
  logic        rpt_valid_q;
  logic [7:0]  rpt_id_q;
  logic        rpt_lost_q;
  logic [7:0]  reject_q;
  logic        save_req;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_alt_q <= 32'h00000000;
      alt_set_q <= 1'b0;
    end else if (alt_load) begin
      ref_alt_q <= word0;
      alt_set_q <= 1'b1;
    end else if (alt_cancel) begin
      ref_alt_q <= 32'h00000000;
      alt_set_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_q      <= 96'h0;
      pos_load_q <= 1'b0;
      pos_acc_q  <= 1'b0;
      survey_q   <= 7'h00;
    end else begin
      pos_load_q <= geo_load || acc_ok;
      if (geo_load || acc_ok) pos_q <= {word0, word1, word2};
      if (acc_ok) begin
        pos_acc_q <= 1'b1;
        survey_q  <= SURVEY_FULL;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tow_q       <= 32'h00000000;
      week_q      <= 16'h0000;
      time_load_q <= 1'b0;
    end else begin
      time_load_q <= time_apply;
      if (time_apply) begin
        tow_q  <= word0;
        week_q <= half2;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sat_q <= 8'h00;
      opt_q <= OPT_RESET;
    end else begin
      if (sat_ok) sat_q <= buf_q[0];
      if (opt_load) opt_q <= word0;
    end
  end

  // Persistence strobes; accurate position only on save
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nv_q     <= 1'b0;
      nv_pos_q <= 1'b0;
    end else begin
      nv_q     <= alt_load || alt_cancel || opt_load || save_req;
      nv_pos_q <= save_req && pos_acc_q;
    end
  end

  // Reset on acquisition with altitude too high
  wire [31:0] alt_used = alt_set_q ? ref_alt_q : i_fix3d_alt;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) force_q <= 1'b0;
    else force_q <= i_sat_acquired && alt_set_q && alt_over(ref_alt_q);
  end

  // Report queue of one; overrun is flagged
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rpt_valid_q <= 1'b0;
      rpt_id_q    <= 8'h00;
    end else if (rpt_want) begin
      rpt_valid_q <= 1'b1;
      rpt_id_q    <= rpt_sel;
    end else if (i_rpt_ready) begin
      rpt_valid_q <= 1'b0;
    end
  end

  // Avalon-MM slave
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         bus_req  = (i_avs_read || i_avs_write) && !ack_q;
  wire         wr_fire  = i_avs_write && ack_q;
  wire         clr_stat = wr_fire && i_avs_address == REG_STATUS;
  assign save_req = wr_fire && i_avs_address == REG_CTRL && i_avs_writedata[CTRL_SAVE_BIT];
  wire [7:0]   rejects_w = reject_q;
  wire [31:0]  status_w = {rejects_w, rpt_lost_q, pos_acc_q, survey_q, alt_set_q, 6'h00,
                           sat_q};
  wire [31:0]  rd_mux = (i_avs_address == REG_STATUS)  ? status_w :
                        (i_avs_address == REG_OPTIONS) ? opt_q :
                        (i_avs_address == REG_REF_ALT) ? ref_alt_q : 32'h00000000;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && i_avs_read) rdata_q <= rd_mux;
    end
  end

  // Sticky lost-report flag and reject counter; a new event wins over a clear
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rpt_lost_q <= 1'b0;
      reject_q   <= 8'h00;
    end else begin
      if (rpt_want && rpt_valid_q && !i_rpt_ready) rpt_lost_q <= 1'b1;
      else if (clr_stat) rpt_lost_q <= 1'b0;
      if (pkt_end && !any_ok || rx.done && long_q) begin
        if (reject_q != 8'hFF) reject_q <= reject_q + 8'h01;
      end else if (clr_stat) reject_q <= 8'h00;
    end
  end

  // Outputs
  assign o_rpt_valid        = rpt_valid_q;
  assign o_rpt_id           = rpt_id_q;
  assign o_alt_used         = alt_used;
  assign o_alt_set          = alt_set_q;
  assign o_alt_is_sea_level = opt_q[OPT_ALT_IN_BIT];
  assign o_force_reset      = force_q;
  assign o_init_pos         = pos_q;
  assign o_init_pos_load    = pos_load_q;
  assign o_pos_accurate     = pos_acc_q;
  assign o_survey_pct       = survey_q;
  assign o_tow              = tow_q;
  assign o_week             = week_q;
  assign o_time_load        = time_load_q;
  assign o_sat_sel          = sat_q;
  assign o_options          = opt_q;
  assign o_nv_store         = nv_q;
  assign o_nv_store_pos     = nv_pos_q;
  assign o_avs_readdata     = rdata_q;
  assign o_avs_waitrequest  = bus_req;

  // Checks
  a_alt_load_report: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    alt_load |=> (ref_alt_q == $past(word0) && alt_set_q && o_rpt_id == RPT_POS_GEO))
    else $error("altitude command not stored or answered");
  a_alt_cancel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    alt_cancel |=> (ref_alt_q == 32'h00000000 && !alt_set_q))
    else $error("altitude cancel did not clear");
  a_alt_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !alt_set_q |-> o_alt_used == i_fix3d_alt)
    else $error("altitude hold not using last fix");
  a_alt_persist: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (alt_load || alt_cancel) |=> o_nv_store)
    else $error("altitude change not persisted");
  a_force_reset: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_sat_acquired && alt_set_q && !ref_alt_q[31] && ref_alt_q[30:0] > ALT_LIMIT_F32[30:0])
    |=> o_force_reset)
    else $error("high altitude acquisition did not force reset");
  a_geo_ignored: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (geo_ok && i_navigating && !acc_ok) |=> (!o_init_pos_load && $stable(o_init_pos)))
    else $error("approximate position taken while navigating");
  a_time_ignored: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (time_ok && i_time_from_sat) |=> (!o_time_load && $stable(o_week) && $stable(o_tow)))
    else $error("time command applied after satellite time");
  a_acc_survey: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    acc_ok |=> (o_survey_pct == SURVEY_FULL && o_pos_accurate && !o_nv_store_pos))
    else $error("accurate position not marked complete");
  a_opt_query: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    opt_query |=> ($stable(o_options) && o_rpt_valid && o_rpt_id == RPT_OPTIONS))
    else $error("option query changed options or no report");
  a_bad_len: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (pkt_end && !any_ok) |=> ($stable(o_options) && $stable(o_sat_sel) && $stable(ref_alt_q)))
    else $error("bad length command changed settings");
  a_bus_answer: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ($rose(i_avs_read) && !ack_q) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not in one cycle");

  c_alt_load: cover property (@(posedge i_core_clk) disable iff (!i_nrst) alt_load);
  c_acc_pos: cover property (@(posedge i_core_clk) disable iff (!i_nrst) acc_ok);
  c_opt_load: cover property (@(posedge i_core_clk) disable iff (!i_nrst) opt_load);
  c_sat_sel: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    sat_ok && buf_q[0] != 8'h00);
endmodule
`default_nettype wire

// File: nrc_host_model.sv
// Host model: frames command packets onto the byte link.
// Assumes bytes are taken at rising edges of the core clock.
`timescale 1ns/1ns
`default_nettype none
module nrc_host_model
  import nrc_pkg::*;
(
  // Clock
  input  wire logic  i_core_clk,
  // Link bytes
  output logic       o_valid,
  output logic [7:0] o_byte
);
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    o_valid <= 1'b1;
    o_byte  <= b;
    @(posedge i_core_clk);
  endtask
  task automatic send(input logic [7:0] id, input int n, input logic [95:0] d);
    logic [7:0] b;
    @(posedge i_core_clk);
    put(BYTE_DLE);
    put(id);
    for (int k = 0; k < n; k++) begin
      b = d[95-8*k -: 8];
      put(b);
      if (b == BYTE_DLE) put(BYTE_DLE);
    end
    put(BYTE_DLE);
    put(BYTE_ETX);
    o_valid <= 1'b0;
    o_byte  <= 8'hFC;
  endtask
endmodule
`default_nettype wire

// File: nrc_decoder_tb.sv
// Testbench: command packets and register reads against the decoder.
// Assumes the host model sends bytes and the bench sinks reports.
`timescale 1ns/1ns
`default_nettype none
module nrc_decoder_tb;
  import nrc_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, rx_v, nav = 1'b0, tsat = 1'b0;
  logic        acq = 1'b0, rdy = 1'b0, rd = 1'b0, wr = 1'b0, clr = 1'b0;
  logic        rv, aset, sea, frst, ipl, pacc, tld, nvs, nvp, wq;
  logic [7:0]  rx_b, rid, sat;
  logic [6:0]  svy;
  logic [15:0] wk;
  logic [3:0]  adr = 4'h0;
  logic [4:0]  seen = 5'h0;
  logic [31:0] fix = 32'h3F800000, wd = 32'h0, rdd, rdv, used, opt, tow;
  logic [95:0] ipos;
  localparam logic [95:0] P = 96'h3E800000_BF000000_44100000;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk) seen <= clr ? 5'h0 : (seen | {tld, ipl, nvp, nvs, frst});
  nrc_host_model host_u (.i_core_clk(clk), .o_valid(rx_v), .o_byte(rx_b));
  nrc_decoder dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_rx_valid(rx_v),
    .i_rx_byte(rx_b), .i_navigating(nav), .i_time_from_sat(tsat),
    .i_sat_acquired(acq), .i_fix3d_alt(fix), .o_rpt_valid(rv), .o_rpt_id(rid),
    .i_rpt_ready(rdy), .o_alt_used(used), .o_alt_set(aset),
    .o_alt_is_sea_level(sea), .o_force_reset(frst), .o_init_pos(ipos),
    .o_init_pos_load(ipl), .o_pos_accurate(pacc), .o_survey_pct(svy),
    .o_tow(tow), .o_week(wk), .o_time_load(tld), .o_sat_sel(sat),
    .o_options(opt), .o_nv_store(nvs), .o_nv_store_pos(nvp),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdd), .o_avs_waitrequest(wq));
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge clk); while (wq !== 1'b0);
    rdv = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pkt(input logic [7:0] id, input int n, input logic [95:0] d,
                     input logic [7:0] rp);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    host_u.send(id, n, d);
    repeat (3) @(posedge clk);
    chk("rpt_valid", rp != 8'h00, rv);
    if (rp != 8'h00) chk("rpt_id", rp, rid);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("opt_rst", OPT_RESET, opt);
    chk("pos_rst", 96'h0, ipos);
    chk("sat_rst", 8'h00, sat);
    av(1'b0, REG_OPTIONS, 32'h0);
    chk("opt_reg", OPT_RESET, rdv);
    pkt(CMD_ALT_2D, 4, {32'h47101000, 64'h0}, RPT_POS_GEO);
    chk("alt_used", 32'h47101000, used);
    chk("alt_set", 1'b1, aset);
    chk("nv_alt", 1'b1, seen[1]);
    av(1'b0, REG_REF_ALT, 32'h0);
    chk("ref_alt_reg", 32'h47101000, rdv);
    acq <= 1'b1;
    @(posedge clk);
    acq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("force_reset", 1'b1, seen[0]);
    pkt(CMD_ALT_2D, 3, 96'h0, 8'h00);
    chk("alt_kept", 32'h47101000, used);
    av(1'b0, REG_STATUS, 32'h0);
    chk("rejects", 8'h01, rdv[31:24]);
    pkt(CMD_ALT_2D, 1, {8'hFF, 88'h0}, RPT_POS_GEO);
    chk("alt_clr", 1'b0, aset);
    chk("alt_hold", fix, used);
    nav <= 1'b1;
    pkt(CMD_POS_GEO, 12, P, RPT_POS_INIT);
    chk("pos_ignored", 96'h0, ipos);
    chk("no_pos_load", 1'b0, seen[3]);
    nav <= 1'b0;
    pkt(CMD_POS_GEO, 12, P, RPT_POS_INIT);
    chk("pos_set", P, ipos);
    chk("pos_load", 1'b1, seen[3]);
    pkt(CMD_OSC_REQ, 0, 96'h0, RPT_OSC);
    pkt(CMD_LEAP_REQ, 0, 96'h0, RPT_LEAP);
    pkt(CMD_TIME, 6, {32'h4B000000, 16'h0810, 48'h0}, RPT_TIME_ACK);
    chk("tow", 32'h4B000000, tow);
    chk("week", 16'h0810, wk);
    chk("time_load", 1'b1, seen[4]);
    tsat <= 1'b1;
    pkt(CMD_TIME, 6, {32'h3F800000, 16'h0001, 48'h0}, RPT_TIME_ACK);
    chk("tow_kept", 32'h4B000000, tow);
    chk("no_time_load", 1'b0, seen[4]);
    pkt(CMD_ACC_GEO, 12, P, RPT_ACC_POS);
    chk("survey", SURVEY_FULL, svy);
    chk("pos_acc", 1'b1, pacc);
    chk("no_nv_pos", 1'b0, seen[2]);
    av(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("nv_pos", 1'b1, seen[2]);
    pkt(CMD_SAT_SEL, 1, {8'h20, 88'h0}, 8'h00);
    chk("sat_32", 8'h20, sat);
    pkt(CMD_SAT_SEL, 1, 96'h0, 8'h00);
    chk("sat_auto", 8'h00, sat);
    pkt(CMD_OPTIONS, 0, 96'h0, RPT_OPTIONS);
    chk("opt_kept", OPT_RESET, opt);
    pkt(CMD_OPTIONS, 4, {32'h08000000, 64'h0}, RPT_OPTIONS);
    chk("opt_set", 32'h08000000, opt);
    chk("nv_opt", 1'b1, seen[1]);
    chk("sea_level", 1'b1, sea);
    av(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rdv);
    end_of_test;
  end
endmodule
`default_nettype wire
